// file: rtl/scpip_params.svh
// Constants of the program message parser: characters, values, depths
// Assumes ASCII bytes arrive from the message bus one per clock
//
// Functional notes
// - Header letters match in any mix of upper and lower case
// - A trailing question mark reports the setting instead of changing it
// - Query with DEF, MIN or MAX returns default, lowest or largest value
// - Only the full long form or exact short form is accepted
// - Words of four letters or fewer have only their full form
// - Longer word, fourth letter vowel or y: short form is three letters
// - Longer word, fourth letter consonant: short form is four letters
// - Query mark and mandatory suffix are kept in the short form too
// - Optional words may be left out and are implied
// - A common command is an asterisk and a three-letter code
// - Semicolons split one message into several commands
// - Each message starts at root; an optional root may be skipped
// - A colon moves one level down; after a semicolon the level stays
// - A colon right after a semicolon returns the pointer to root
// - The path pointer moves up only when it returns to root
// - Common commands run at any level and leave the pointer alone
// - Commands of a message run in their written order
// - Invalid command flags an error; earlier run, later ones ignored
// - Responses wait in the output queue until addressed to talk
// - Responses in query order, semicolon between, comma between items
// - Every response message ends in line feed with the end signal
// - Header and parameter are separated by at least one space
`ifndef SCPIP_PARAMS_SVH
`define SCPIP_PARAMS_SVH
`define SCPIP_CH_LF    8'h0a
`define SCPIP_CH_SP    8'h20
`define SCPIP_CH_STAR  8'h2a
`define SCPIP_CH_COMMA 8'h2c
`define SCPIP_CH_COLON 8'h3a
`define SCPIP_CH_SEMI  8'h3b
`define SCPIP_CH_QMARK 8'h3f
`define SCPIP_WORD_MAX 4'hc
`define SCPIP_OPT_ROOT 3'h5
`define SCPIP_VAL_MIN  4'h0
`define SCPIP_VAL_MAX  4'h9
`define SCPIP_ENAB_DEF 4'h0
`define SCPIP_DEL_DEF  4'h1
`define SCPIP_ESE_DEF  4'h0
// Identity digits returned by the identify query; values are arbitrary
`define SCPIP_ID_A     4'h1
`define SCPIP_ID_B     4'h2
`define SCPIP_OQ_DEPTH 16
`endif

// file: rtl/scpip_pkg.sv
// Types and the command tree of the program message parser
// Assumes the constants header is available for inclusion
package scpip_pkg;
   typedef enum logic [1:0] {ST_HDR, ST_PARAM, ST_SKIP, ST_EMIT} scpip_state_type;
   typedef enum logic [1:0] {COM_NONE, COM_RST, COM_ESE, COM_IDN} scpip_com_type;
   typedef struct packed {
      logic [2:0]       parent;
      logic [11:0][7:0] word;
      logic [3:0]       len;
      logic             cmd;
      logic             num;
   } scpip_node_type;
   localparam int NODE_N = 7;
   // Node 0 is the root; node 5 is an optional root word
   localparam scpip_node_type NODES [NODE_N] = '{
      '{3'h0, 96'h0,        4'h0, 1'b0, 1'b0},
      '{3'h0, 96'("STATUS"),    4'h6, 1'b0, 1'b0},
      '{3'h1, 96'("OPERATION"), 4'h9, 1'b0, 1'b0},
      '{3'h2, 96'("ENABLE"),    4'h6, 1'b1, 1'b1},
      '{3'h1, 96'("PRESET"),    4'h6, 1'b1, 1'b0},
      '{3'h0, 96'("SENSE"),     4'h5, 1'b0, 1'b0},
      '{3'h5, 96'("DELAY"),     4'h5, 1'b1, 1'b1}};
endpackage

// file: rtl/scpip_word_match.sv
// Compares one received command word with one long form of the tree
// Assumes both words are upper case, last character at index 0
`timescale 1ns/10ps
module scpip_word_match (
   input  wire logic [11:0][7:0] word,
   input  wire logic [3:0]       wlen,
   input  wire logic [11:0][7:0] lword,
   input  wire logic [3:0]       llen,
   output logic                  match
);
   function automatic logic is_vowel(input logic [7:0] c);
      return c inside {8'h41, 8'h45, 8'h49, 8'h4f, 8'h55, 8'h59};
   endfunction

   always_comb
   begin
      logic [3:0] slen;
      logic       eq;
      slen = llen;
      if (llen > 4'h4)
         slen = is_vowel(lword[4'(llen - 4'h4)]) ? 4'h3 : 4'h4;
      eq = 1'b1;
      for (int i = 0; i < 12; i++)
         if (4'(i) < wlen && word[4'(wlen - 4'(i) - 4'h1)] != lword[4'(llen - 4'(i) - 4'h1)])
            eq = 1'b0;
      match = eq && wlen != 4'h0 && (wlen == llen || wlen == slen);
   end
endmodule

// file: rtl/scpip_skid_buf.sv
// Two-entry buffer between the output queue and the talker port
// Assumes the drain side may hold out_ready low for any time
`timescale 1ns/10ps
module scpip_skid_buf #(
   parameter int W = 9
) (
   input  wire logic         sys_clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] in_data,
   input  wire logic         in_valid,
   output logic              in_ready,
   output logic [W-1:0]      out_data,
   output logic              out_valid,
   input  wire logic         out_ready
);
   typedef struct packed {
      logic [W-1:0] out;
      logic         ov;
      logic [W-1:0] spare;
      logic         sv;
      logic         rdy;
   } scpip_skid_type;
   scpip_skid_type s_r;
   scpip_skid_type s_nxt;

   always_comb
   begin
      s_nxt = s_r;
      if (out_ready || !s_r.ov)
      begin
         // A held word leaves first so order is kept
         if (s_r.sv)
         begin
            s_nxt.out = s_r.spare;
            s_nxt.ov  = 1'b1;
            s_nxt.sv  = 1'b0;
         end
         else
         begin
            s_nxt.out = in_data;
            s_nxt.ov  = in_valid && s_r.rdy;
         end
      end
      else if (in_valid && s_r.rdy)
      begin
         s_nxt.spare = in_data;
         s_nxt.sv    = 1'b1;
      end
      s_nxt.rdy = !s_nxt.sv;
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         s_r <= '{out: '0, ov: 1'b0, spare: '0, sv: 1'b0, rdy: 1'b1};
      else
         s_r <= s_nxt;
   end

   assign in_ready  = s_r.rdy;
   assign out_data  = s_r.out;
   assign out_valid = s_r.ov;

   a_skid_hold: assert property (@(posedge sys_clk) disable iff (rst)
      out_valid && !out_ready |=> out_valid && $stable(out_data))
      else $error("Stalled output word changed");
endmodule

// file: rtl/scpip_parser.sv
// Program message parser: header matching, path pointer, execution, output queue
// Assumes host bytes and talk address come from logic on sys_clk
`timescale 1ns/10ps
`include "scpip_params.svh"
module scpip_parser #(
   parameter int OQ_DEPTH = `SCPIP_OQ_DEPTH
) (
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic [7:0] rx_data,
   input  wire logic       rx_valid,
   input  wire logic       rx_eoi,
   output logic            rx_ready,
   input  wire logic       talk_en,
   output logic [7:0]      tx_data,
   output logic            tx_eoi,
   output logic            tx_valid,
   input  wire logic       tx_ready,
   output logic            exec_pulse,
   output logic [2:0]      exec_node,
   output logic [3:0]      exec_value,
   output logic            exec_query,
   output logic            exec_common,
   output logic            err_pulse,
   output logic [2:0]      path_level
);
   localparam int PW = $clog2(OQ_DEPTH);
   localparam int NN = scpip_pkg::NODE_N;

   typedef struct packed {
      scpip_pkg::scpip_state_type st;
      logic [2:0]                 level;
      logic                       start;
      logic [11:0][7:0]           buf_w;
      logic [3:0]                 wlen;
      logic                       com;
      logic                       qry;
      logic [2:0]                 hn;
      scpip_pkg::scpip_com_type   hc;
      logic                       hq;
      logic                       hcom;
      logic                       anyq;
      logic [NN-1:0][3:0]         vals;
      logic [4:0][8:0]            ebuf;
      logic [2:0]                 elen;
      logic [2:0]                 eidx;
      logic [OQ_DEPTH-1:0][8:0]   q;
      logic [PW-1:0]              wp;
      logic [PW-1:0]              rp;
      logic [PW:0]                cnt;
      logic                       rdy;
      logic                       exec;
      logic [2:0]                 xnode;
      logic [3:0]                 xval;
      logic                       xq;
      logic                       xcom;
      logic                       err;
   } scpip_core_type;

   scpip_core_type s_r;
   scpip_core_type s_nxt;
   logic [NN-1:0]  m;
   logic           pop;
   logic           skid_rdy;
   logic [8:0]     skid_out;
   logic           fin;
   logic           fterm;
   logic           fcom;
   logic           ok;

   // ****************************************
   // Decoding helpers
   // ****************************************
   function automatic logic [3:0] pick(input logic [NN-1:0] mv, input logic [2:0] lv);
      logic [3:0] r;
      r = 4'h0;
      for (int n = NN - 1; n > 0; n--)
         if (mv[n] && (scpip_pkg::NODES[n].parent == lv
             || (lv == 3'h0 && scpip_pkg::NODES[n].parent == `SCPIP_OPT_ROOT)))
            r = {1'b1, 3'(n)};
      return r;
   endfunction

   function automatic scpip_pkg::scpip_com_type com_code(input logic [23:0] w);
      case (w)
         "RST":   return scpip_pkg::COM_RST;
         "ESE":   return scpip_pkg::COM_ESE;
         "IDN":   return scpip_pkg::COM_IDN;
         default: return scpip_pkg::COM_NONE;
      endcase
   endfunction

   function automatic logic [3:0] def_val(input logic [2:0] slot);
      case (slot)
         3'h3:    return `SCPIP_ENAB_DEF;
         3'h6:    return `SCPIP_DEL_DEF;
         default: return `SCPIP_ESE_DEF;
      endcase
   endfunction

   function automatic logic is_alnum(input logic [7:0] c);
      return c inside {[8'h30:8'h39], [8'h41:8'h5a]};
   endfunction

   // ****************************************
   // Word matchers, one per tree node below the root
   // ****************************************
   assign m[0] = 1'b0;
   for (genvar g = 1; g < NN; g++)
   begin : g_match
      scpip_word_match u_m (
         .word  (s_r.buf_w),
         .wlen  (s_r.wlen),
         .lword (scpip_pkg::NODES[g].word),
         .llen  (scpip_pkg::NODES[g].len),
         .match (m[g])
      );
   end

   // ****************************************
   // Parser state
   // ****************************************
   always_comb
   begin
      logic [7:0]               c;
      logic                     take;
      logic                     push;
      logic [8:0]               pdata;
      logic [3:0]               res;
      logic                     hok;
      scpip_pkg::scpip_com_type cc;
      logic [2:0]               fn;
      scpip_pkg::scpip_com_type fc;
      logic                     fq;
      logic                     fempty;
      logic                     fpar;
      logic                     isnum;
      logic [2:0]               slot;
      logic [23:0]              k3;
      logic                     dig;
      logic [3:0]               v;
      logic [4:0][8:0]          eb;
      logic [2:0]               e;
      c      = (rx_data inside {[8'h61:8'h7a]}) ? rx_data - 8'h20 : rx_data;
      take   = rx_valid && s_r.rdy;
      push   = 1'b0;
      pdata  = 9'h000;
      res    = pick(m, s_r.level);
      cc     = com_code(s_r.buf_w[2:0]);
      hok    = s_r.com ? (s_r.wlen == 4'h3 && cc != scpip_pkg::COM_NONE)
                       : (res[3] && scpip_pkg::NODES[res[2:0]].cmd);
      fin    = 1'b0;
      fterm  = take && (c == `SCPIP_CH_LF || rx_eoi);
      fn     = res[2:0];
      fc     = cc;
      fq     = s_r.qry;
      fcom   = s_r.com;
      fempty = s_r.wlen == 4'h0 && !s_r.com;
      fpar   = 1'b0;
      ok     = 1'b1;
      eb     = '0;
      e      = 3'h0;
      v      = 4'h0;
      s_nxt  = s_r;
      s_nxt.exec = 1'b0;
      s_nxt.err  = 1'b0;
      case (s_r.st)
         scpip_pkg::ST_HDR:
            if (take)
            begin
               if (fterm || c == `SCPIP_CH_SEMI)
               begin
                  fin = 1'b1;
                  // A header that names no command of this level must not run
                  ok  = hok || fempty;
               end
               else if (c == `SCPIP_CH_SP && hok)
               begin
                  s_nxt.hn   = res[2:0];
                  s_nxt.hc   = cc;
                  s_nxt.hq   = s_r.qry;
                  s_nxt.hcom = s_r.com;
                  s_nxt.wlen = 4'h0;
                  s_nxt.st   = scpip_pkg::ST_PARAM;
               end
               else if (c == `SCPIP_CH_COLON && fempty && s_r.start)
               begin
                  s_nxt.level = 3'h0;
                  s_nxt.start = 1'b0;
               end
               else if (c == `SCPIP_CH_COLON && !s_r.com && !s_r.qry && res[3]
                        && !scpip_pkg::NODES[res[2:0]].cmd)
               begin
                  // Only a child of the present level is found, so never upward
                  s_nxt.level = res[2:0];
                  s_nxt.wlen  = 4'h0;
                  s_nxt.start = 1'b0;
               end
               else if (c == `SCPIP_CH_STAR && fempty)
               begin
                  s_nxt.com   = 1'b1;
                  s_nxt.start = 1'b0;
               end
               else if (c == `SCPIP_CH_QMARK && s_r.wlen != 4'h0 && !s_r.qry)
                  s_nxt.qry = 1'b1;
               else if (is_alnum(c) && !s_r.qry && s_r.wlen != `SCPIP_WORD_MAX)
               begin
                  s_nxt.buf_w = {s_r.buf_w[10:0], c};
                  s_nxt.wlen  = s_r.wlen + 4'h1;
                  s_nxt.start = 1'b0;
               end
               else
               begin
                  s_nxt.err = 1'b1;
                  s_nxt.st  = scpip_pkg::ST_SKIP;
               end
            end
         scpip_pkg::ST_PARAM:
            if (take)
            begin
               fn     = s_r.hn;
               fc     = s_r.hc;
               fq     = s_r.hq;
               fcom   = s_r.hcom;
               fempty = 1'b0;
               fpar   = s_r.wlen != 4'h0;
               if (fterm || c == `SCPIP_CH_SEMI)
                  fin = 1'b1;
               else if (is_alnum(c) && s_r.wlen != `SCPIP_WORD_MAX)
               begin
                  s_nxt.buf_w = {s_r.buf_w[10:0], c};
                  s_nxt.wlen  = s_r.wlen + 4'h1;
               end
               else if (c != `SCPIP_CH_SP)
               begin
                  s_nxt.err = 1'b1;
                  s_nxt.st  = scpip_pkg::ST_SKIP;
               end
            end
         scpip_pkg::ST_SKIP:
            if (fterm)
            begin
               fin    = 1'b1;
               fempty = 1'b1;
            end
         scpip_pkg::ST_EMIT:
            if (s_r.cnt < (PW+1)'(OQ_DEPTH))
            begin
               push        = 1'b1;
               pdata       = s_r.ebuf[s_r.eidx];
               s_nxt.eidx  = s_r.eidx + 3'h1;
               if (s_r.eidx + 3'h1 == s_r.elen)
                  s_nxt.st = scpip_pkg::ST_HDR;
            end
         default:
            s_nxt.st = scpip_pkg::ST_HDR;
      endcase

      // ****************************************
      // Execution of one finished command
      // ****************************************
      isnum = fcom ? fc == scpip_pkg::COM_ESE : scpip_pkg::NODES[fn].num;
      slot  = fcom ? 3'h0 : fn;
      k3    = {s_r.buf_w[4'(s_r.wlen - 4'h1)], s_r.buf_w[4'(s_r.wlen - 4'h2)],
               s_r.buf_w[4'(s_r.wlen - 4'h3)]};
      dig   = s_r.wlen == 4'h1 && s_r.buf_w[0] inside {[8'h30:8'h39]};
      if (fin && !fempty)
      begin
         if (!isnum)
            ok = ok && !fpar && fq == (fcom && fc == scpip_pkg::COM_IDN);
         else
         begin
            v  = s_r.vals[slot];
            ok = ok && (fq || fpar);
            if (fpar && dig && !fq)
               v = s_r.buf_w[0][3:0];
            else if (fpar && s_r.wlen >= 4'h3 && k3 == "DEF")
               v = def_val(slot);
            else if (fpar && s_r.wlen >= 4'h3 && k3 == "MIN")
               v = `SCPIP_VAL_MIN;
            else if (fpar && s_r.wlen >= 4'h3 && k3 == "MAX")
               v = `SCPIP_VAL_MAX;
            else if (fpar)
               ok = 1'b0;
            if (ok && fq && fpar)
               ok = 1'b1;
         end
         if (ok)
         begin
            // Commands leave in arrival order as one pulse each
            s_nxt.exec  = 1'b1;
            s_nxt.xnode = fcom ? 3'h0 : fn;
            s_nxt.xval  = v;
            s_nxt.xq    = fq;
            s_nxt.xcom  = fcom;
            if (isnum && !fq)
               s_nxt.vals[slot] = v;
            if (!isnum && !fq && (fcom || fn == 3'h4))
            begin
               s_nxt.vals[3] = `SCPIP_ENAB_DEF;
               s_nxt.vals[6] = `SCPIP_DEL_DEF;
            end
            if (fq)
            begin
               if (s_r.anyq)
               begin
                  eb[e] = {1'b0, `SCPIP_CH_SEMI};
                  e     = e + 3'h1;
               end
               if (fcom && fc == scpip_pkg::COM_IDN)
               begin
                  eb[e]        = {5'h03, `SCPIP_ID_A};
                  eb[e + 3'h1] = {1'b0, `SCPIP_CH_COMMA};
                  eb[e + 3'h2] = {5'h03, `SCPIP_ID_B};
                  e            = e + 3'h3;
               end
               else
               begin
                  eb[e] = {5'h03, v};
                  e     = e + 3'h1;
               end
               s_nxt.anyq = 1'b1;
            end
         end
         else
         begin
            s_nxt.err = 1'b1;
            if (!fterm)
               s_nxt.st = scpip_pkg::ST_SKIP;
         end
      end
      if (fin)
      begin
         s_nxt.wlen  = 4'h0;
         s_nxt.com   = 1'b0;
         s_nxt.qry   = 1'b0;
         s_nxt.start = 1'b1;
         if (ok || fterm)
            s_nxt.st = scpip_pkg::ST_HDR;
         if (fterm)
         begin
            if (s_nxt.anyq)
            begin
               eb[e] = {1'b1, `SCPIP_CH_LF};
               e     = e + 3'h1;
            end
            s_nxt.anyq  = 1'b0;
            s_nxt.level = 3'h0;
         end
         if (e != 3'h0)
         begin
            s_nxt.ebuf = eb;
            s_nxt.elen = e;
            s_nxt.eidx = 3'h0;
            s_nxt.st   = scpip_pkg::ST_EMIT;
         end
      end

      // ****************************************
      // Output queue
      // ****************************************
      if (push)
      begin
         s_nxt.q[s_r.wp] = pdata;
         s_nxt.wp        = s_r.wp + PW'(1);
      end
      if (pop)
         s_nxt.rp = s_r.rp + PW'(1);
      s_nxt.cnt = s_r.cnt + (PW+1)'(push) - (PW+1)'(pop);
      s_nxt.rdy = s_nxt.st != scpip_pkg::ST_EMIT;
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         s_r         <= '0;
         s_r.start   <= 1'b1;
         s_r.rdy     <= 1'b1;
         s_r.vals[0] <= `SCPIP_ESE_DEF;
         s_r.vals[3] <= `SCPIP_ENAB_DEF;
         s_r.vals[6] <= `SCPIP_DEL_DEF;
      end
      else
         s_r <= s_nxt;
   end

   // Nothing leaves until the controller addresses the block to talk
   assign pop = talk_en && s_r.cnt != '0 && skid_rdy;

   scpip_skid_buf #(.W(9)) u_skid (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .in_data   (s_r.q[s_r.rp]),
      .in_valid  (pop),
      .in_ready  (skid_rdy),
      .out_data  (skid_out),
      .out_valid (tx_valid),
      .out_ready (tx_ready)
   );

   assign tx_data     = skid_out[7:0];
   assign tx_eoi      = skid_out[8];
   assign rx_ready    = s_r.rdy;
   assign exec_pulse  = s_r.exec;
   assign exec_node   = s_r.xnode;
   assign exec_value  = s_r.xval;
   assign exec_query  = s_r.xq;
   assign exec_common = s_r.xcom;
   assign err_pulse   = s_r.err;
   assign path_level  = s_r.level;

   // ****************************************
   // Checks
   // ****************************************
   a_level_down: assert property (@(posedge sys_clk) disable iff (rst)
      s_r.level != $past(s_r.level) |-> s_r.level == 3'h0
         || scpip_pkg::NODES[s_r.level].parent == $past(s_r.level))
      else $error("Path pointer moved upward");
   a_common_keep: assert property (@(posedge sys_clk) disable iff (rst)
      fin && fcom && ok && !fterm |=> s_r.level == $past(s_r.level))
      else $error("Common command moved the path pointer");
   a_skip_quiet: assert property (@(posedge sys_clk) disable iff (rst)
      s_r.st == scpip_pkg::ST_SKIP |-> !s_r.exec)
      else $error("Command ran after an error");
   a_query_hold: assert property (@(posedge sys_clk) disable iff (rst)
      s_r.exec && s_r.xq |-> s_r.vals == $past(s_r.vals))
      else $error("Query changed a setting");
   a_msg_root: assert property (@(posedge sys_clk) disable iff (rst)
      fterm && fin |=> s_r.level == 3'h0 && s_r.start && !s_r.anyq)
      else $error("Message did not return to root");
   a_tx_term: assert property (@(posedge sys_clk) disable iff (rst)
      tx_valid && tx_eoi |-> tx_data == `SCPIP_CH_LF)
      else $error("End signal without line feed");
   a_short_len: assert property (@(posedge sys_clk) disable iff (rst)
      m[3] |-> s_r.wlen == 4'h6 || s_r.wlen == 4'h4)
      else $error("Word matched with an in-between length");
endmodule

// file: testbench/scpip_host_model.sv
// Host controller model: takes response bytes, can stall the talker port
// Assumes the bench sends program messages and drives the talk address
`timescale 1ns/10ps
module scpip_host_model (
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic [7:0] tx_data,
   input  wire logic       tx_eoi,
   input  wire logic       tx_valid,
   output logic            tx_ready,
   input  wire logic       slow
);
   string      rsp = "";
   logic [1:0] cnt_r = 2'h0;
   // Slow mode takes one byte in four so the output buffer backs up
   assign tx_ready = slow ? (cnt_r == 2'h3) : 1'b1;
   always @(posedge sys_clk)
   begin
      cnt_r <= cnt_r + 2'h1;
      if (!rst && tx_valid && tx_ready)
      begin
         rsp = $sformatf("%s%c", rsp, tx_data);
         if (tx_eoi === 1'b1)
            rsp = {rsp, "$"};
      end
   end
endmodule

// file: testbench/scpi_program_message_parser_test.sv
// Self-checking bench of the program message parser
// Assumes the host model drains responses; bench drives bytes at negedge
`timescale 1ns/10ps
module scpi_program_message_parser_test;
   logic            sys_clk = 1'b0;
   logic            rst = 1'b1;
   logic [7:0]      rx_data = 8'h00;
   logic            rx_valid = 1'b0;
   logic            rx_eoi = 1'b0;
   logic            talk_en = 1'b0;
   logic            slow = 1'b0;
   logic            rx_ready, tx_eoi, tx_valid, tx_ready, exec_pulse;
   logic            exec_query, exec_common, err_pulse;
   logic [7:0]      tx_data;
   logic [2:0]      exec_node, path_level;
   logic [3:0]      exec_value;
   int              bad_count = 0;
   int              n_checks = 0;
   int              cyc = 0;
   string           elog = "";
   initial forever #12.5 sys_clk = ~sys_clk;
   scpip_parser #(.OQ_DEPTH(16)) i_scpip_parser (.sys_clk(sys_clk), .rst(rst),
      .rx_data(rx_data), .rx_valid(rx_valid), .rx_eoi(rx_eoi), .rx_ready(rx_ready),
      .talk_en(talk_en), .tx_data(tx_data), .tx_eoi(tx_eoi), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .exec_pulse(exec_pulse), .exec_node(exec_node),
      .exec_value(exec_value), .exec_query(exec_query), .exec_common(exec_common),
      .err_pulse(err_pulse), .path_level(path_level));
   scpip_host_model i_scpip_host_model (.sys_clk(sys_clk), .rst(rst), .tx_data(tx_data),
      .tx_eoi(tx_eoi), .tx_valid(tx_valid), .tx_ready(tx_ready), .slow(slow));
   // ****************************************
   // Execution log and timeout
   // ****************************************
   // Identify reports no settable value, so common queries log a q
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         bad_count++;
         report_and_stop();
      end
      if (exec_pulse === 1'b1)
         elog = $sformatf("%s%h%c%c", elog, exec_node, (exec_common && exec_query) ?
                8'h71 : 8'h30 + {4'h0, exec_value}, exec_query ? 8'h3f : 8'h3d);
      if (err_pulse === 1'b1)
         elog = {elog, "E"};
   end
   task automatic cmp_str(input string got, input string exp);
      n_checks++;
      if (got != exp)
      begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Message ends in a line feed, or in a trailing space carrying the end signal
   task automatic send(input string s, input bit eoi);
      s = {s, eoi ? " " : "\n"};
      for (int i = 0; i < s.len(); i++)
      begin
         @(negedge sys_clk);
         rx_data = s[i];
         rx_valid = 1'b1;
         rx_eoi = eoi && (i == s.len() - 1);
         while (rx_ready !== 1'b1) @(negedge sys_clk);
      end
      @(negedge sys_clk);
      rx_valid = 1'b0;
      rx_eoi = 1'b0;
   endtask
   task automatic run(input string msg, input bit eoi, input string e_log, input string e_rsp);
      elog = "";
      i_scpip_host_model.rsp = "";
      send(msg, eoi);
      repeat (8) @(negedge sys_clk);
      cmp_str(elog, e_log);
      cmp_str($sformatf("%h", path_level), "0");
      cmp_str(i_scpip_host_model.rsp, "");
      talk_en = 1'b1;
      // Always wait a while so that a stray response cannot slip past
      for (int i = 0; i < 400 && (i < 16 || i_scpip_host_model.rsp != e_rsp); i++)
         @(negedge sys_clk);
      cmp_str(i_scpip_host_model.rsp, e_rsp);
      talk_en = 1'b0;
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_case_path;
      run("sTaT:oPeR:EnAb 7", 0, "37=", "");
      run("STATUS:OPERATION:ENABLE?", 1, "37?", "7\n$");
   endtask
   task automatic t_short_root;
      run("SENS:DEL 4", 0, "64=", "");
      run("del?", 0, "64?", "4\n$");
   endtask
   task automatic t_multi;
      run("stat:oper:enab 2;enab?;*ese 3;enab?;:sens:del?", 0,
          "32=32?03=32?64?", "2;2;4\n$");
   endtask
   task automatic t_error;
      run("*ese?;statu:pres;*ese 1", 0, "0q?E", "3\n$");
      run("*ESE?", 0, "0q?", "3\n$");
      run("stat:oper:enab 1;pres;*ese 2", 0, "31=E", "");
      run("*ese5", 0, "E", "");
   endtask
   task automatic t_limits;
      slow = 1'b1;
      run("del? min;DEL? MAX;del? def;*idn?", 1,
          "60?69?61?0q?", "0;9;1;1,2\n$");
      slow = 1'b0;
   endtask
   task automatic t_reset;
      run("stat:oper:enab 5;*rst;enab?", 0, "35=00=30?", "0\n$");
      run("del 8;stat:pres;:del?", 0, "68=40=61?", "1\n$");
   endtask
   task automatic report_and_stop;
      $display("checks=%0d mismatches=%0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      repeat (12) @(negedge sys_clk);
      cmp_str($sformatf("%b%b%b%h", rx_ready, tx_valid, err_pulse, path_level), "1000");
      rst = 1'b0;
      t_case_path();
      t_short_root();
      t_multi();
      t_error();
      t_limits();
      t_reset();
      report_and_stop();
   end
endmodule
